// ===== hdl/usb_mcu_interrupt_controller.sv
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
module usb_mcu_interrupt_controller
  import intc_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // avalon-mm slave, word addressed
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // source events, one-cycle pulses
  input  wire logic        i_tick_128us,
  input  wire logic        i_tick_1024us,
  input  wire logic [4:0]  i_ep_event,
  input  wire logic        i_hub_event,
  input  wire logic        i_dac_event,
  input  wire logic        i_gpio_event,
  input  wire logic        i_hw_parallel_port_event,
  input  wire logic        i_i2c_event,
  // upstream line levels
  input  wire logic        i_up_dp,
  input  wire logic        i_up_dm,
  // cpu sequencer side
  input  wire logic        i_instr_done,
  input  wire logic        i_mask_all_op,
  input  wire logic        i_unmask_all_op,
  input  wire logic        i_return_from_isr_op,
  input  wire logic [15:0] i_pc,
  input  wire logic        i_carry_flag,
  input  wire logic        i_zero_flag,
  input  wire logic [17:0] i_pop_word,
  output logic             o_cpu_hold,
  output logic             o_push_stb,
  output logic      [17:0] o_push_word,
  output logic             o_vector_load,
  output logic      [15:0] o_vector_addr,
  output logic             o_restore_stb,
  output logic      [15:0] o_restore_pc,
  output logic             o_restore_carry_flag,
  output logic             o_restore_zero_flag,
  output logic             o_gie,
  output logic             o_irq_pending,
  // bus reset side effects
  input  wire logic        i_startup_active,
  output logic             o_startup_abort,
  output logic             o_usb_reg_clr_stb,
  output logic      [7:0]  o_usb_reg_clr_addr
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [GLB_EN_W-1:0] glb_en;
    logic [EP_EN_W-1:0]  ep_en;
    logic                hpp_en;
    logic [NUM_SRC-1:0]  pend;
    logic                gie;
    logic                bus_rst;
    logic [7:0]          se0_cnt;
    logic                se0_det;
    seq_state_t          st;
    logic [3:0]          call_cnt;
    logic [3:0]          vec_idx;
    logic [17:0]         push_word;
    logic [15:0]         vec_addr;
    logic                vec_load;
    logic                restore;
    logic [17:0]         pop_word;
    logic [3:0]          clr_idx;
    logic                clr_act;
    logic                abort;
    logic                bus_ack;
    logic [31:0]         rdata;
  } ctl_state_t;

  ctl_state_t s_r;
  ctl_state_t s_nxt;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // lowest index wins, so vector 1 beats vector 12
  function automatic logic [3:0] first_req(input logic [NUM_SRC-1:0] req);
    logic [3:0] idx;
    idx = 4'h0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (req[k]) idx = 4'(k);
    end
    return idx;
  endfunction : first_req

  // vector address of a source index
  function automatic logic [15:0] vec_of(input logic [3:0] idx);
    return 16'(({12'h000, idx} + 16'h0001) * VEC_STRIDE);
  endfunction : vec_of

  // bus-reset wipe table entry
  function automatic logic [7:0] clr_addr(input logic [3:0] idx);
    return CLR_TABLE[{idx, 3'b000} +: 8];
  endfunction : clr_addr

  //////////////////////////////////////////////////////////////////////////////
  // combinational terms

  logic [NUM_SRC-1:0] evt;
  logic [NUM_SRC-1:0] en_vec;
  logic [NUM_SRC-1:0] req;
  logic [3:0]         win_idx;
  logic               take;
  logic               se0;
  logic               se0_end;
  logic               bus_req;
  logic               wr_ok;
  logic [7:0]         status_byte;

  assign se0     = ~i_up_dp & ~i_up_dm;
  // the interrupt fires on the trailing edge of the reset
  assign se0_end = s_r.se0_det & ~se0;

  // gpio vector is owned by the parallel port when it is on
  always_comb begin
    evt = '0;
    evt[SRC_BUS_RST] = se0_end;
    evt[1] = i_tick_128us;
    evt[2] = i_tick_1024us;
    evt[SRC_EP_BASE +: EP_EN_W] = i_ep_event;
    evt[8] = i_hub_event;
    evt[9] = i_dac_event;
    evt[SRC_GPIO] = s_r.hpp_en ? i_hw_parallel_port_event
                               : i_gpio_event;
    evt[11] = i_i2c_event;
  end

  // enables laid out in vector order
  assign en_vec = {s_r.glb_en[6:3], s_r.ep_en, s_r.glb_en[2:0]};
  assign req    = s_r.pend & en_vec;
  assign win_idx = first_req(req);
  // only at an instruction boundary, never mid-call
  assign take = (s_r.st == ST_IDLE) & i_instr_done & s_r.gie
              & (|req);

  assign bus_req = i_avs_read | i_avs_write;
  assign wr_ok   = i_avs_write & s_r.bus_ack & i_avs_byteenable[0];

  assign status_byte = {|s_r.pend, 1'b0, s_r.bus_rst, 2'b00,
                        s_r.gie, 2'b00};

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_nxt = s_r;
    s_nxt.vec_load = 1'b0;
    s_nxt.restore  = 1'b0;
    s_nxt.abort    = 1'b0;

    // bus handshake: one wait state, then answer
    s_nxt.bus_ack = bus_req & ~s_r.bus_ack;
    if (bus_req & ~s_r.bus_ack) begin
      case (i_avs_address)
        IDX_GLB_EN:  s_nxt.rdata = {25'h0, s_r.glb_en};
        IDX_EP_EN:   s_nxt.rdata = {27'h0, s_r.ep_en};
        IDX_PENDING: s_nxt.rdata = {20'h0, s_r.pend};
        IDX_STATUS:  s_nxt.rdata = {24'h0, status_byte};
        IDX_CTRL:    s_nxt.rdata = {31'h0, s_r.hpp_en};
        default:     s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // software writes; the status gie bit ignores writes
    if (wr_ok) begin
      case (i_avs_address)
        IDX_GLB_EN: s_nxt.glb_en = i_avs_writedata[GLB_EN_W-1:0];
        IDX_EP_EN:  s_nxt.ep_en  = i_avs_writedata[EP_EN_W-1:0];
        IDX_STATUS: s_nxt.bus_rst = i_avs_writedata[STS_BRST_BIT];
        IDX_CTRL:   s_nxt.hpp_en  = i_avs_writedata[CTRL_HPP_BIT];
        default: ;
      endcase
    end

    // mask and unmask change the global flag only; return also latches the pop word
    if (i_mask_all_op) s_nxt.gie = 1'b0;
    if (i_unmask_all_op) s_nxt.gie = 1'b1;
    if (i_return_from_isr_op) begin
      s_nxt.gie      = 1'b1;
      s_nxt.restore  = 1'b1;
      s_nxt.pop_word = i_pop_word;
    end

    // upstream se0 timing, saturating counter
    if (se0) begin
      if (s_r.se0_cnt != 8'(SE0_DET_CYC)) begin
        s_nxt.se0_cnt = s_r.se0_cnt + 8'h01;
      end
    end else begin
      s_nxt.se0_cnt = 8'h00;
      s_nxt.se0_det = 1'b0;
    end
    if (se0 & ~s_r.se0_det & (s_r.se0_cnt == 8'(SE0_DET_CYC - 1))) begin
      s_nxt.se0_det = 1'b1;
      s_nxt.bus_rst = 1'b1;
      s_nxt.clr_act = 1'b1;
      s_nxt.clr_idx = 4'h0;
      s_nxt.abort   = i_startup_active;
    end

    // walk the wipe table one register per cycle
    if (s_r.clr_act) begin
      if (s_r.clr_idx == 4'(NUM_CLR - 1)) begin
        s_nxt.clr_act = 1'b0;
      end else begin
        s_nxt.clr_idx = s_r.clr_idx + 4'h1;
      end
    end

    // acknowledge and call sequencing
    case (s_r.st)
      ST_IDLE: begin
        if (take) begin
          s_nxt.gie       = 1'b0;
          s_nxt.pend[win_idx] = 1'b0;
          s_nxt.vec_idx   = win_idx;
          s_nxt.push_word = {i_zero_flag, i_carry_flag, i_pc};
          s_nxt.call_cnt  = 4'(CALL_CYCLES - 1);
          s_nxt.st        = ST_CALL;
        end
      end
      ST_CALL: begin
        // vector lands in the last held cycle, so the call spans ten
        if (s_r.call_cnt == 4'h1) begin
          s_nxt.vec_load = 1'b1;
          s_nxt.vec_addr = vec_of(s_r.vec_idx);
        end
        if (s_r.call_cnt == 4'h0) begin
          s_nxt.st       = ST_IDLE;
        end else begin
          s_nxt.call_cnt = s_r.call_cnt - 4'h1;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    // new events set pending last, so they beat the acknowledge clear
    s_nxt.pend = s_nxt.pend | evt;
    // a write of zero loses to a bus reset detected together
    if (s_r.se0_cnt == 8'(SE0_DET_CYC - 1) & se0 & ~s_r.se0_det) begin
      s_nxt.bus_rst = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers; reset leaves every interrupt disabled

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_r          <= '0;
      s_r.vec_addr <= RESET_VECTOR;
      s_r.st       <= ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_avs_waitrequest    = bus_req & ~s_r.bus_ack;
  assign o_avs_readdata       = s_r.rdata;
  // cpu stalls for the whole injected call
  assign o_cpu_hold           = (s_r.st == ST_CALL);
  assign o_push_stb           = (s_r.st == ST_CALL)
                              & (s_r.call_cnt == 4'(CALL_CYCLES - 1));
  assign o_push_word          = s_r.push_word;
  assign o_vector_load        = s_r.vec_load;
  assign o_vector_addr        = s_r.vec_addr;
  assign o_restore_stb        = s_r.restore;
  assign o_restore_pc         = s_r.pop_word[15:0];
  assign o_restore_carry_flag = s_r.pop_word[16];
  assign o_restore_zero_flag  = s_r.pop_word[17];
  assign o_gie                = s_r.gie;
  assign o_irq_pending        = status_byte[STS_IRQ_BIT];
  assign o_startup_abort      = s_r.abort;
  assign o_usb_reg_clr_stb    = s_r.clr_act;
  assign o_usb_reg_clr_addr   = s_r.clr_act ? clr_addr(s_r.clr_idx) : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_ack_drops_gie: assert property (take |=> !s_r.gie)
    else $error("global enable not cleared on acknowledge");

  a_ack_at_boundary: assert property (
    take |-> i_instr_done && s_r.gie)
    else $error("acknowledge away from an instruction boundary");

  a_prio_order: assert property (
    take |-> ((req & ((12'h001 << win_idx) - 12'h001)) == 12'h000))
    else $error("lower vector skipped");

  a_pend_clears: assert property (
    take && !evt[win_idx] |=> !s_r.pend[$past(win_idx)])
    else $error("serviced pending flop not cleared");

  a_event_kept: assert property (
    |evt |=> ((s_r.pend & $past(evt)) == $past(evt)))
    else $error("event lost");

  a_call_latency: assert property (
    take |-> ##1 o_push_stb ##9 (o_vector_load
      && o_vector_addr == vec_of($past(win_idx, 10))))
    else $error("call did not take ten cycles");

  a_se0_by_max: assert property (
    se0 && s_r.se0_cnt == 8'(SE0_DET_CYC - 1) |=> s_r.se0_det && s_r.bus_rst)
    else $error("bus reset not detected in time");

  a_rst_evt_end: assert property (
    s_r.se0_det && !se0 |=> s_r.pend[SRC_BUS_RST])
    else $error("bus reset interrupt not raised at end of se0");

  a_flag_ops_only: assert property (
    (i_mask_all_op || i_unmask_all_op) && !wr_ok
      |=> $stable(s_r.glb_en) && $stable(s_r.ep_en))
    else $error("flag op touched enable registers");

  a_return_gie: assert property (
    i_return_from_isr_op && !i_mask_all_op |=> o_gie && o_restore_stb)
    else $error("return did not restore");

  a_wipe_walk: assert property (
    $rose(o_usb_reg_clr_stb) |-> o_usb_reg_clr_addr == 8'h10
      ##9 o_usb_reg_clr_addr == 8'h51)
    else $error("register wipe sequence wrong");

  // restored word is the one popped with the return op
  a_restore_word: assert property (
    i_return_from_isr_op |=> {o_restore_zero_flag, o_restore_carry_flag,
      o_restore_pc} == $past(i_pop_word))
    else $error("restored flags or pc differ from the popped word");

  // a lone mask op drops the global flag at the next edge
  a_mask_op: assert property (
    i_mask_all_op && !i_unmask_all_op && !i_return_from_isr_op |=> !o_gie)
    else $error("mask op left the global flag set");

  // the abort pulse follows detection, only while start-up runs
  a_abort_pulse: assert property (
    $rose(s_r.se0_det) |-> o_startup_abort == $past(i_startup_active))
    else $error("start-up abort does not follow bus reset detection");

  // the cpu is held for exactly the ten call cycles
  a_hold_span: assert property (
    o_push_stb |-> o_cpu_hold [*8] ##1 o_cpu_hold [*2] ##1 !o_cpu_hold)
    else $error("cpu hold does not span the call");

  // a pending flop never rises without an event behind it
  a_pend_source: assert property (
    1'b1 |=> ((s_r.pend & ~$past(s_r.pend) & ~$past(evt)) == 12'h000))
    else $error("pending flop set with no event");

  c_irq_taken:  cover property (take ##10 o_vector_load);
  c_masked_latch: cover property (|evt && !s_r.gie);
  c_bus_reset:  cover property ($rose(s_r.se0_det) ##[1:50] se0_end);
  c_coincide:   cover property (take && evt[win_idx]);
  c_reg_read:   cover property (i_avs_read && !o_avs_waitrequest);

endmodule : usb_mcu_interrupt_controller

// ===== pkg/intc_pkg.sv
// Overview of operation
// - every source is masked until software writes its enable bit to one
// - global bits 0..6: reset, 128us, 1.024ms, hub, dac, gpio, i2c; 7 free
// - endpoint enables: a0..a2 in bits 0..2, b0..b1 in bits 3..4
// - any reset clears both enable registers
// - each source has its own pending flop, held until serviced or reset
// - a pending flop requests only while its enable bit is set
// - service starts only when the current instruction completes
// - acknowledge clears the cpu global enable, shown at status bit 2
// - acknowledge clears the serviced pending flop and injects vector call
// - injected call pushes program counter, carry and zero flags only
// - return from isr restores pc, carry, zero and sets global enable
// - mask and unmask ops touch only the global enable flag
// - any pending interrupt is reported at status bit 7
// - lower vector number wins; bus reset highest, i2c lowest
// - execution after reset starts at zero; vectors are two bytes apart
// - vectors 0x0002 bus reset up to 0x0018 i2c, in vector order
// - latency is remaining cycles plus ten for call plus five for jump
// - bus reset is both data lines low; detect after 12us, surely by 16us
// - bus reset detection sets status bit 5
// - bus reset clears address regs 0x10, 0x40 and hub regs 0x48..0x4A, 0x4D..0x51
// - bus reset interrupt is raised when the low-low condition ends
// - bus reset during the power-on start-up delay aborts the delay
// - enabled parallel port owns the gpio vector, gated by global bit 5
package intc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_GLB_EN   = 8'h20;
  localparam logic [7:0] IDX_EP_EN    = 8'h21;
  localparam logic [7:0] IDX_PENDING  = 8'h22;
  localparam logic [7:0] IDX_STATUS   = 8'h23;
  localparam logic [7:0] IDX_CTRL     = 8'h24;

  // field positions
  localparam int GLB_EN_W      = 7;
  localparam int EP_EN_W       = 5;
  localparam int NUM_SRC       = 12;
  localparam int STS_GIE_BIT   = 2;
  localparam int STS_BRST_BIT  = 5;
  localparam int STS_IRQ_BIT   = 7;
  localparam int CTRL_HPP_BIT  = 0;
  localparam int GLB_GPIO_BIT  = 5;

  // source indices, in priority order
  localparam int SRC_BUS_RST   = 0;
  localparam int SRC_EP_BASE   = 3;
  localparam int SRC_GPIO      = 10;

  // vectors
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VEC_STRIDE   = 16'h0002;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SE0_MIN_NS    = 12000;
  localparam int SE0_MAX_NS    = 16000;
  localparam int SE0_DET_CYC   =
    (SE0_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SE0_MAX_CYC   = SE0_MAX_NS / CLK_PERIOD_NS;
  localparam int CALL_CYCLES   = 10;
  localparam int JMP_CYCLES    = 5;

  // registers wiped on bus reset
  localparam int NUM_CLR = 10;
  localparam logic [79:0] CLR_TABLE = {
    8'h51, 8'h50, 8'h4F, 8'h4E, 8'h4D, 8'h4A, 8'h49, 8'h48, 8'h40, 8'h10};

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CALL = 1'b1
  } seq_state_t;

endpackage : intc_pkg

// ===== tb/cpu_model.sv
`timescale 1ns/1ns
module cpu_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // from the controller
  input  wire logic        i_cpu_hold,
  input  wire logic        i_vector_load,
  input  wire logic [15:0] i_vector_addr,
  // to the controller
  output logic             o_instr_done,
  output logic      [15:0] o_pc,
  output logic             o_carry_flag,
  output logic             o_zero_flag,
  // word offered at the last instruction end, for the bench
  output logic      [17:0] o_last_word
);
  logic [1:0] cnt_r;

  ////////////////////////////////////////
  // three-cycle instructions, none end while the call runs
  assign o_instr_done = (cnt_r == 2'h2) && !i_cpu_hold;
  // flags follow pc bits so every push differs
  assign o_carry_flag = o_pc[0];
  assign o_zero_flag  = o_pc[1];

  // sequencer: step pc per instruction, jump on vector load
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r       <= 2'h0;
      o_pc        <= 16'h0000;
      o_last_word <= 18'h00000;
    end else if (i_vector_load) begin
      cnt_r <= 2'h0;
      o_pc  <= i_vector_addr;
    end else if (o_instr_done) begin
      cnt_r       <= 2'h0;
      o_pc        <= o_pc + 16'h0001;
      o_last_word <= {o_zero_flag, o_carry_flag, o_pc};
    end else if (!i_cpu_hold) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule : cpu_model

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import intc_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic we = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [15:0] stim = 16'h0000;
  logic [17:0] pop = 18'h00000;
  logic dp = 1'b1;
  logic dm = 1'b0;
  logic startup = 1'b0;
  logic done, cf, zf;
  logic [15:0] pc;
  logic [17:0] last_word;
  logic [31:0] rdata, q;
  logic wreq, hold, push, vload, rstb, rcf, rzf, gie, irqp, clr, abort;
  logic [17:0] push_w;
  logic [15:0] vaddr, rpc;
  logic [7:0] clr_a;
  logic [7:0] clr_q[$];
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int aborts = 0;
  // vector per source, bus reset first
  localparam logic [15:0] VEC_EXP [12] = '{16'h0002, 16'h0004, 16'h0006,
    16'h0008, 16'h000A, 16'h000C, 16'h000E, 16'h0010, 16'h0012, 16'h0014,
    16'h0016, 16'h0018};
  localparam logic [7:0] CLR_EXP [10] = '{8'h10, 8'h40, 8'h48, 8'h49,
    8'h4A, 8'h4D, 8'h4E, 8'h4F, 8'h50, 8'h51};
  // register rows: index, write data, read back
  localparam logic [23:0] ROWS [7] = '{24'h20FF7F, 24'h21FF1F, 24'h30AA00,
    24'h22FF00, 24'h230400, 24'h207F7F, 24'h211F1F};

  ////////////////////////////////////////
  always #50 i_clk = ~i_clk;

  usb_mcu_interrupt_controller dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(we),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_tick_128us(stim[1]), .i_tick_1024us(stim[2]),
    .i_ep_event(stim[7:3]), .i_hub_event(stim[8]), .i_dac_event(stim[9]),
    .i_gpio_event(stim[10]), .i_hw_parallel_port_event(stim[15]),
    .i_i2c_event(stim[11]), .i_up_dp(dp), .i_up_dm(dm),
    .i_instr_done(done), .i_mask_all_op(stim[12]),
    .i_unmask_all_op(stim[13]), .i_return_from_isr_op(stim[14]),
    .i_pc(pc), .i_carry_flag(cf), .i_zero_flag(zf), .i_pop_word(pop),
    .o_cpu_hold(hold), .o_push_stb(push), .o_push_word(push_w),
    .o_vector_load(vload), .o_vector_addr(vaddr), .o_restore_stb(rstb),
    .o_restore_pc(rpc), .o_restore_carry_flag(rcf),
    .o_restore_zero_flag(rzf), .o_gie(gie), .o_irq_pending(irqp),
    .i_startup_active(startup), .o_startup_abort(abort),
    .o_usb_reg_clr_stb(clr), .o_usb_reg_clr_addr(clr_a));

  cpu_model cpu (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cpu_hold(hold),
    .i_vector_load(vload), .i_vector_addr(vaddr), .o_instr_done(done),
    .o_pc(pc), .o_carry_flag(cf), .o_zero_flag(zf),
    .o_last_word(last_word));

  // side-effect monitor: wipe addresses and abort pulses
  always @(negedge i_clk) begin
    if (clr === 1'b1) clr_q.push_back(clr_a);
    if (abort === 1'b1) aborts++;
  end

  // hang guard, generous against a few hundred cycles of tests
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  ////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  // one avalon cycle; request held until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
           output logic [31:0] r);
    @(posedge i_clk);
    adr <= a;
    rd <= !w;
    we <= w;
    wd <= {24'h0, d};
    @(posedge i_clk);
    while (wreq !== 1'b0) @(posedge i_clk);
    r = rdata;
    rd <= 1'b0;
    we <= 1'b0;
  endtask : bus

  // one-cycle pulse on events and cpu ops
  task pulse(input logic [15:0] m);
    @(posedge i_clk);
    stim <= m;
    @(posedge i_clk);
    stim <= 16'h0000;
  endtask : pulse

  // follow one acknowledge through to the return
  task serve(input logic [15:0] v);
    int n;
    n = 0;
    @(negedge i_clk);
    while (push !== 1'b1 && n < 80) begin
      n++;
      @(negedge i_clk);
    end
    chk(push_w, last_word);
    chk(gie, 0);
    n = 1;
    while (vload !== 1'b1 && n < 80) begin
      n++;
      @(negedge i_clk);
    end
    chk(n, 10);
    chk(vaddr, v);
    @(posedge i_clk);
    stim[14] <= 1'b1;
    pop <= 18'h21234;
    @(posedge i_clk);
    stim <= 16'h0000;
    @(negedge i_clk);
    chk({rstb, gie, rzf, rcf, rpc}, 20'hE1234);
  endtask : serve

  task end_of_test;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    bus(0, 8'h20, 8'h00, q);
    chk(q, 0);
    bus(0, 8'h21, 8'h00, q);
    chk(q, 0);
    foreach (ROWS[i]) begin
      bus(1, ROWS[i][23:16], ROWS[i][15:8], q);
      bus(0, ROWS[i][23:16], 8'h00, q);
      chk(q, {24'h0, ROWS[i][7:0]});
    end
    // every source but bus reset in turn, gie restored by each return
    pulse(16'h2000);
    for (int i = 1; i < 12; i++) begin
      pulse(16'h0001 << i);
      serve(VEC_EXP[i]);
    end
    // masked and disabled requests stay latched
    pulse(16'h1000);
    @(negedge i_clk);
    chk(gie, 0);
    pulse(16'h0A02);
    bus(0, 8'h22, 8'h00, q);
    chk(q, 32'hA02);
    bus(0, 8'h20, 8'h00, q);
    chk(q, 32'h7F);
    bus(0, 8'h23, 8'h00, q);
    chk({q[7], q[2], irqp}, 3'h5);
    bus(1, 8'h20, 8'h7D, q);
    pulse(16'h2000);
    serve(16'h0014);
    serve(16'h0018);
    bus(0, 8'h22, 8'h00, q);
    chk(q, 32'h002);
    pulse(16'h1000);
    bus(1, 8'h20, 8'h7F, q);
    pulse(16'h2000);
    serve(16'h0004);
    // parallel port takes over the gpio vector
    pulse(16'h1000);
    bus(1, 8'h24, 8'h01, q);
    pulse(16'h0400);
    bus(0, 8'h22, 8'h00, q);
    chk(q, 0);
    pulse(16'h8000);
    bus(0, 8'h22, 8'h00, q);
    chk(q, 32'h400);
    pulse(16'h2000);
    serve(16'h0016);
    bus(1, 8'h24, 8'h00, q);
    // bus reset during start-up, interrupt only once the lines recover
    @(posedge i_clk);
    startup <= 1'b1;
    dp <= 1'b0;
    repeat (125) @(posedge i_clk);
    bus(0, 8'h23, 8'h00, q);
    chk(q[5], 1);
    bus(0, 8'h22, 8'h00, q);
    chk(q, 0);
    dp <= 1'b1;
    startup <= 1'b0;
    serve(16'h0002);
    chk(aborts, 1);
    chk(clr_q.size(), 10);
    foreach (CLR_EXP[i]) chk(clr_q[i], CLR_EXP[i]);
    // reset in mid-run wipes the enables
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    bus(0, 8'h20, 8'h00, q);
    chk(q, 0);
    bus(0, 8'h21, 8'h00, q);
    chk({q[30:0], gie}, 0);
    end_of_test();
  end
endmodule : testbench
